// >>> logic/bpt_trigger_unit.sv
// Eight address-match breakpoint triggers with CSR-style access and trap outputs.
// Assumes the pipeline presents one access per cycle and a CSR port in the same clock.
// Behaviour
// - Trigger kind field is four bits, read-only, reads 2 except for a debug-claimed trigger read from machine mode.
// - Action 0 raises breakpoint exception, action 1 enters debug mode.
// - Load, store, fetch enables filter matches; every combination honoured.
// - Machine, supervisor, user enables filter by privilege; all combinations.
// - Four-bit match type: exact, power-of-two range, arbitrary range.
// - Arbitrary range: lower trigger bottom, higher trigger one above top.
// - Trailing ones in address low bits give power-of-two range size.
// - Six-bit read-only field gives log2 of largest supported range.
// - Largest range: low 3 bits ones, bit 3 zero, bits 31 to 4 compared.
// - Chain: first trigger greater-or-equal, second less-than, both must hit.
// - Match-address register is full-width read and write.
// - Traps are precise; trapping and younger instructions do not commit.
// - Any byte of a misaligned access inside the range triggers.
// - Debug action goes to debug vector, machine registers unchanged.
// - Machine trap records breakpoint cause and faulting address.
// - Trigger claimed by debug mode reads kind 0 from machine mode.
// - Eight triggers per hart selected through an index register.
// - Machine access to debug-only trigger data raises illegal instruction.
// - Largest-range field reads fixed 4, ranges up to 16 bytes.
`timescale 1ns/10ps
module bpt_trigger_unit #(
  parameter int NUM_TRIG = bpt_pkg::BPT_NUM_TRIG
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // CSR port
  input  wire logic        csr_req,
  input  wire logic        csr_we,
  input  wire logic [1:0]  csr_sel,
  input  wire logic [31:0] csr_wdata,
  input  wire logic        csr_debug_mode,
  output logic      [31:0] csr_rdata,
  output logic             csr_illegal,
  // Access stream
  input  wire logic        acc_valid,
  input  wire logic [2:0]  acc_kind,
  input  wire logic [1:0]  acc_priv,
  input  wire logic [31:0] acc_addr,
  input  wire logic [2:0]  acc_size_log2,
  // Trap outputs
  output logic             trap_exc,
  output logic             trap_debug,
  output logic             trap_kill,
  output logic      [3:0]  trap_cause,
  output logic      [31:0] trap_badaddr
);
  localparam logic [1:0] SEL_INDEX = 2'h0;
  localparam logic [1:0] SEL_WORD1 = 2'h1;
  localparam logic [1:0] SEL_WORD2 = 2'h2;

  logic [2:0]  index_reg, index_next;
  logic        load_en_reg   [NUM_TRIG];
  logic        store_en_reg  [NUM_TRIG];
  logic        fetch_en_reg  [NUM_TRIG];
  logic        user_en_reg   [NUM_TRIG];
  logic        super_en_reg  [NUM_TRIG];
  logic        mach_en_reg   [NUM_TRIG];
  logic [3:0]  mtype_reg     [NUM_TRIG];
  logic        chain_reg     [NUM_TRIG];
  logic [5:0]  action_reg    [NUM_TRIG];
  logic        dmode_reg     [NUM_TRIG];
  logic [31:0] maddr_reg     [NUM_TRIG];
  logic [31:0] word1         [NUM_TRIG];
  logic        hit           [NUM_TRIG];
  logic        fire          [NUM_TRIG];
  logic        exc_next, dbg_next;
  logic [31:0] badaddr_reg, badaddr_next;
  logic        exc_reg, dbg_reg;
  logic        access_ok;
  logic        write_w1, write_w2;

  logic [31:0] acc_last;
  assign acc_last = acc_addr + ((32'h0000_0001 << acc_size_log2) - 32'h0000_0001);

  // Machine mode may not touch debug-only trigger data
  assign access_ok = csr_debug_mode || (csr_sel == SEL_INDEX)
                     || !dmode_reg[index_reg];
  assign csr_illegal = csr_req && !access_ok;
  assign write_w1 = csr_req && csr_we && access_ok && (csr_sel == SEL_WORD1);
  assign write_w2 = csr_req && csr_we && access_ok && (csr_sel == SEL_WORD2);

  always_comb begin
    index_next = index_reg;
    if (csr_req && csr_we && csr_sel == SEL_INDEX) begin
      index_next = csr_wdata[2:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TRIG; g++) begin : g_trig
      logic [3:0]  mt_next;
      logic [5:0]  act_next;
      logic [9:0]  ctl_next;
      logic        dm_next;
      logic [31:0] ma_next;
      logic [31:0] care;
      logic        in_napot, ge_hit, lt_hit, kind_ok, priv_ok;

      always_comb begin
        mt_next  = mtype_reg[g];
        act_next = action_reg[g];
        ctl_next = {chain_reg[g], mach_en_reg[g], super_en_reg[g], user_en_reg[g],
                    fetch_en_reg[g], store_en_reg[g], load_en_reg[g], 3'h0};
        dm_next  = dmode_reg[g];
        ma_next  = maddr_reg[g];
        if (write_w1 && index_reg == 3'(g)) begin
          ctl_next = {csr_wdata[bpt_pkg::BPT_CHAIN_BIT], csr_wdata[bpt_pkg::BPT_MACH_BIT],
                      csr_wdata[bpt_pkg::BPT_SUPER_BIT], csr_wdata[bpt_pkg::BPT_USER_BIT],
                      csr_wdata[bpt_pkg::BPT_FETCH_BIT], csr_wdata[bpt_pkg::BPT_STORE_BIT],
                      csr_wdata[bpt_pkg::BPT_LOAD_BIT], 3'h0};
          if (csr_wdata[bpt_pkg::BPT_MATCH_LSB +: 4] <= bpt_pkg::BPT_MT_LT) begin
            mt_next = csr_wdata[bpt_pkg::BPT_MATCH_LSB +: 4];
          end
          if (csr_wdata[bpt_pkg::BPT_ACTION_LSB +: 6] <= bpt_pkg::BPT_ACT_DEBUG) begin
            act_next = csr_wdata[bpt_pkg::BPT_ACTION_LSB +: 6];
          end
          if (csr_debug_mode) begin
            dm_next = csr_wdata[bpt_pkg::BPT_DMODE_BIT];
          end
        end
        if (write_w2 && index_reg == 3'(g)) begin
          ma_next = csr_wdata;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          {chain_reg[g], mach_en_reg[g], super_en_reg[g], user_en_reg[g],
           fetch_en_reg[g], store_en_reg[g], load_en_reg[g]} <= 7'h00;
          mtype_reg[g]  <= bpt_pkg::BPT_MT_EXACT;
          action_reg[g] <= bpt_pkg::BPT_ACT_EXC;
          dmode_reg[g]  <= 1'b0;
          maddr_reg[g]  <= bpt_pkg::BPT_ADDR_RST;
        end else begin
          {chain_reg[g], mach_en_reg[g], super_en_reg[g], user_en_reg[g],
           fetch_en_reg[g], store_en_reg[g], load_en_reg[g]} <= ctl_next[9:3];
          mtype_reg[g]  <= mt_next;
          action_reg[g] <= act_next;
          dmode_reg[g]  <= dm_next;
          maddr_reg[g]  <= ma_next;
        end
      end

      // Mask of compared bits from trailing ones, up to 16 bytes; four trailing ones compare every bit
      always_comb begin
        care = 32'hFFFF_FFFF;
        if (!maddr_reg[g][0]) begin
          care = 32'hFFFF_FFFE;
        end else if (!maddr_reg[g][1]) begin
          care = 32'hFFFF_FFFC;
        end else if (!maddr_reg[g][2]) begin
          care = 32'hFFFF_FFF8;
        end else if (!maddr_reg[g][3]) begin
          care = 32'hFFFF_FFF0;
        end
      end

      // Any byte overlap: first byte below range end, last byte at or above range start
      assign in_napot = ((acc_addr & care) <= (maddr_reg[g] & care))
                        && ((acc_last & care) >= (maddr_reg[g] & care));
      assign ge_hit   = acc_last >= maddr_reg[g];
      assign lt_hit   = acc_addr < maddr_reg[g];
      assign kind_ok  = (acc_kind[0] && load_en_reg[g]) || (acc_kind[1] && store_en_reg[g])
                        || (acc_kind[2] && fetch_en_reg[g]);
      assign priv_ok  = (acc_priv == bpt_pkg::BPT_PRIV_M && mach_en_reg[g])
                        || (acc_priv == bpt_pkg::BPT_PRIV_S && super_en_reg[g])
                        || (acc_priv == bpt_pkg::BPT_PRIV_U && user_en_reg[g]);

      always_comb begin
        case (mtype_reg[g])
          bpt_pkg::BPT_MT_EXACT: hit[g] = (acc_addr <= maddr_reg[g]) && (acc_last >= maddr_reg[g]);
          bpt_pkg::BPT_MT_NAPOT: hit[g] = in_napot;
          bpt_pkg::BPT_MT_GE:    hit[g] = ge_hit;
          bpt_pkg::BPT_MT_LT:    hit[g] = lt_hit;
          default:               hit[g] = 1'b0;
        endcase
        hit[g] = hit[g] && kind_ok && priv_ok && acc_valid;
      end

      // Chained trigger holds back its action for the next one
      if (g == 0) begin : g_first
        assign fire[g] = hit[g] && !chain_reg[g];
      end else begin : g_rest
        assign fire[g] = hit[g] && !chain_reg[g]
                         && (!chain_reg[g-1] || hit[g-1]);
      end

      assign word1[g] = {bpt_pkg::BPT_TYPE_ADDR, dmode_reg[g], bpt_pkg::BPT_MASKMAX, 1'b0,
                         2'b00, action_reg[g], chain_reg[g], mtype_reg[g], mach_en_reg[g],
                         1'b0, super_en_reg[g], user_en_reg[g], fetch_en_reg[g],
                         store_en_reg[g], load_en_reg[g]};
    end
  endgenerate

  // Debug action wins when both kinds fire together
  always_comb begin
    exc_next     = 1'b0;
    dbg_next     = 1'b0;
    badaddr_next = badaddr_reg;
    for (int i = 0; i < NUM_TRIG; i++) begin
      if (fire[i] && action_reg[i] == bpt_pkg::BPT_ACT_DEBUG) begin
        dbg_next = 1'b1;
      end
      if (fire[i] && action_reg[i] == bpt_pkg::BPT_ACT_EXC) begin
        exc_next = 1'b1;
      end
    end
    exc_next = exc_next && !dbg_next;
    if (exc_next) begin
      badaddr_next = acc_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      index_reg   <= 3'h0;
      exc_reg     <= 1'b0;
      dbg_reg     <= 1'b0;
      badaddr_reg <= bpt_pkg::BPT_ADDR_RST;
    end else begin
      index_reg   <= index_next;
      exc_reg     <= exc_next;
      dbg_reg     <= dbg_next;
      badaddr_reg <= badaddr_next;
    end
  end

  // Kill is combinational so the matching access never commits
  assign trap_kill    = exc_next || dbg_next;
  assign trap_exc     = exc_reg;
  assign trap_debug   = dbg_reg;
  assign trap_cause   = exc_reg ? bpt_pkg::BPT_CAUSE_BRK : 4'h0;
  assign trap_badaddr = badaddr_reg;

  always_comb begin
    csr_rdata = 32'h0000_0000;
    if (csr_req && access_ok) begin
      case (csr_sel)
        SEL_INDEX: csr_rdata = {29'h0, index_reg};
        SEL_WORD1: csr_rdata = (dmode_reg[index_reg] && !csr_debug_mode)
                               ? {bpt_pkg::BPT_TYPE_NONE, 28'h0}
                               : word1[index_reg];
        SEL_WORD2: csr_rdata = maddr_reg[index_reg];
        default:   csr_rdata = 32'h0000_0000;
      endcase
    end
  end

  illegal_dmode_a: assert property (@(posedge sys_clk) disable iff (rst)
    csr_req && !csr_debug_mode && csr_sel != SEL_INDEX && dmode_reg[index_reg]
    |-> csr_illegal) else $error("machine access to debug trigger not refused");
  type_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    csr_req && csr_sel == SEL_WORD1 && csr_debug_mode
    |-> csr_rdata[31:28] == 4'h2 && csr_rdata[26:21] == 6'h04)
    else $error("kind or range field wrong");
  legal_match_a: assert property (@(posedge sys_clk) disable iff (rst)
    mtype_reg[index_reg] <= 4'h3 && action_reg[index_reg] <= 6'h01)
    else $error("illegal field value stored");
  kill_trap_a: assert property (@(posedge sys_clk) disable iff (rst)
    trap_kill |=> (trap_exc || trap_debug)) else $error("kill without trap");
  exc_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
    trap_exc |-> trap_cause == 4'h3 && trap_badaddr == $past(acc_addr))
    else $error("cause or address wrong");
  debug_excl_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(trap_exc && trap_debug)) else $error("both trap kinds raised");
  no_access_a: assert property (@(posedge sys_clk) disable iff (rst)
    !acc_valid |=> !trap_exc && !trap_debug) else $error("trap without access");
  // Index reads stay visible; only the data words of a debug trigger are hidden
  hidden_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    csr_req && !csr_debug_mode && csr_sel != SEL_INDEX && dmode_reg[index_reg]
    |-> csr_rdata == 32'h0) else $error("debug trigger visible to machine mode");
  addr_write_a: assert property (@(posedge sys_clk) disable iff (rst)
    write_w2 |=> maddr_reg[$past(index_reg)] == $past(csr_wdata))
    else $error("address word not stored");

  exc_seen_c: cover property (@(posedge sys_clk) disable iff (rst) trap_exc);
  dbg_seen_c: cover property (@(posedge sys_clk) disable iff (rst) trap_debug);
  illegal_c:  cover property (@(posedge sys_clk) disable iff (rst) csr_illegal);
endmodule : bpt_trigger_unit

// >>> logic/bpt_pkg.sv
// Package for the breakpoint trigger unit: field layout, reset values, encodings.
// Assumes a single 32-bit hart clock domain.
package bpt_pkg;
  localparam int          BPT_XLEN        = 32;
  localparam int          BPT_NUM_TRIG    = 8;
  localparam int          BPT_IDX_W       = 3;
  // Control word field positions
  localparam int          BPT_LOAD_BIT    = 0;
  localparam int          BPT_STORE_BIT   = 1;
  localparam int          BPT_FETCH_BIT   = 2;
  localparam int          BPT_USER_BIT    = 3;
  localparam int          BPT_SUPER_BIT   = 4;
  localparam int          BPT_MACH_BIT    = 6;
  localparam int          BPT_MATCH_LSB   = 7;
  localparam int          BPT_CHAIN_BIT   = 11;
  localparam int          BPT_ACTION_LSB  = 12;
  localparam int          BPT_MASKMAX_LSB = 21;
  localparam int          BPT_DMODE_BIT   = 27;
  localparam int          BPT_TYPE_LSB    = 28;
  // Fixed values
  localparam logic [3:0]  BPT_TYPE_ADDR   = 4'h2;
  localparam logic [3:0]  BPT_TYPE_NONE   = 4'h0;
  localparam logic [5:0]  BPT_MASKMAX     = 6'h04;
  localparam logic [5:0]  BPT_ACT_EXC     = 6'h00;
  localparam logic [5:0]  BPT_ACT_DEBUG   = 6'h01;
  localparam logic [3:0]  BPT_MT_EXACT    = 4'h0;
  localparam logic [3:0]  BPT_MT_NAPOT    = 4'h1;
  localparam logic [3:0]  BPT_MT_GE       = 4'h2;
  localparam logic [3:0]  BPT_MT_LT       = 4'h3;
  // Reset values and breakpoint cause code
  localparam logic [9:0]  BPT_CTRL_RST    = 10'h000;
  localparam logic [31:0] BPT_ADDR_RST    = 32'h0000_0000;
  localparam logic [3:0]  BPT_CAUSE_BRK   = 4'h3;
  // Privilege encodings
  localparam logic [1:0]  BPT_PRIV_U      = 2'h0;
  localparam logic [1:0]  BPT_PRIV_S      = 2'h1;
  localparam logic [1:0]  BPT_PRIV_M      = 2'h3;
  // Access kinds
  typedef enum logic [2:0] {
    BPT_ACC_LOAD  = 3'b001,
    BPT_ACC_STORE = 3'b010,
    BPT_ACC_FETCH = 3'b100
  } bpt_acc_t;
endpackage : bpt_pkg

// >>> tb/bpt_hart_model.sv
// Hart pipeline model: presents one access per cycle to the trigger unit.
// Assumes requests from the bench, applied at the next rising edge.
`timescale 1ns/10ps
module bpt_hart_model (
  input  wire logic        sys_clk,
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_kind,
  input  wire logic [1:0]  req_priv,
  input  wire logic [31:0] req_addr,
  input  wire logic [2:0]  req_size,
  output logic             acc_valid,
  output logic      [2:0]  acc_kind,
  output logic      [1:0]  acc_priv,
  output logic      [31:0] acc_addr,
  output logic      [2:0]  acc_size_log2
);
  initial begin
    acc_valid = 1'b0;
    acc_kind = 3'h0;
    acc_priv = 2'h0;
    acc_addr = 32'h0000_0000;
    acc_size_log2 = 3'h0;
  end
  // Idle cycles scramble the address so stale values never pass for an access
  always @(posedge sys_clk) begin
    acc_valid <= req_valid;
    acc_kind <= req_valid ? req_kind : 3'h0;
    acc_priv <= req_valid ? req_priv : ~acc_priv;
    acc_addr <= req_valid ? req_addr : ~acc_addr;
    acc_size_log2 <= req_valid ? req_size : ~acc_size_log2;
  end
endmodule : bpt_hart_model

// >>> tb/test_bpt_trigger_unit.sv
// Testbench for the trigger unit: CSR checks and a trap scoreboard.
// Assumes the hart model on the access port and CSR port driven here.
`timescale 1ns/10ps
module test_bpt_trigger_unit;
  typedef struct packed {
    logic        kill;
    logic        exc;
    logic        dbg;
    logic [31:0] bad;
  } bpt_note_t;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        csr_req = 1'b0;
  logic        csr_we = 1'b0;
  logic        csr_debug_mode = 1'b0;
  logic [1:0]  csr_sel = 2'h0;
  logic [31:0] csr_wdata = 32'h0000_0000;
  logic        req_valid = 1'b0;
  logic [2:0]  req_kind = 3'h0;
  logic [1:0]  req_priv = 2'h0;
  logic [31:0] req_addr = 32'h0000_0000;
  logic [2:0]  req_size = 3'h0;
  logic [31:0] csr_rdata, acc_addr, trap_badaddr;
  logic        csr_illegal, acc_valid, trap_exc, trap_debug, trap_kill;
  logic [2:0]  acc_kind, acc_size_log2;
  logic [1:0]  acc_priv;
  logic [3:0]  trap_cause;
  int          n_errors = 0;
  int          n_compared = 0;
  bpt_note_t   notes[$];
  bpt_note_t   pend;
  logic        pend_v = 1'b0;
  logic [31:0] last_bad = 32'h0000_0000;

  bpt_hart_model u_bpt_hart_model (.sys_clk, .req_valid, .req_kind, .req_priv, .req_addr,
    .req_size, .acc_valid, .acc_kind, .acc_priv, .acc_addr, .acc_size_log2);
  bpt_trigger_unit u_bpt_trigger_unit (.sys_clk, .rst, .csr_req, .csr_we, .csr_sel,
    .csr_wdata, .csr_debug_mode, .csr_rdata, .csr_illegal, .acc_valid, .acc_kind,
    .acc_priv, .acc_addr, .acc_size_log2, .trap_exc, .trap_debug, .trap_kill,
    .trap_cause, .trap_badaddr);

  initial forever #5 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic csr(input logic we, input logic [1:0] sel, input logic [31:0] wd,
                     input logic dbg, input logic [31:0] exp, input logic ill);
    @(posedge sys_clk);
    csr_req <= 1'b1;
    csr_we <= we;
    csr_sel <= sel;
    csr_wdata <= wd;
    csr_debug_mode <= dbg;
    #1;
    if (!we) check("csr_rdata", csr_rdata, exp);
    check("csr_illegal", {31'h0, csr_illegal}, {31'h0, ill});
  endtask : csr

  task automatic wr(input logic [1:0] sel, input logic [31:0] wd);
    csr(1'b1, sel, wd, 1'b0, 32'h0000_0000, 1'b0);
  endtask : wr

  task automatic rd(input logic [1:0] sel, input logic [31:0] exp);
    csr(1'b0, sel, 32'h0000_0000, 1'b0, exp, 1'b0);
  endtask : rd

  task automatic acc(input logic [2:0] k, input logic [1:0] p, input logic [31:0] a,
                     input logic [2:0] sz, input logic e, input logic d);
    bpt_note_t n;
    n.kill = e | d;
    n.exc = e & !d;
    n.dbg = d;
    if (n.exc) last_bad = a;
    n.bad = last_bad;
    notes.push_back(n);
    @(posedge sys_clk);
    csr_req <= 1'b0;
    req_valid <= 1'b1;
    req_kind <= k;
    req_priv <= p;
    req_addr <= a;
    req_size <= sz;
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask : acc

  // Scoreboard: kill in the access cycle, trap outputs one cycle later
  always @(posedge sys_clk) begin
    if (pend_v) begin
      check("trap_exc", {31'h0, trap_exc}, {31'h0, pend.exc});
      check("trap_debug", {31'h0, trap_debug}, {31'h0, pend.dbg});
      check("trap_cause", {28'h0, trap_cause}, pend.exc ? 32'h3 : 32'h0);
      check("trap_badaddr", trap_badaddr, pend.bad);
    end
    pend_v <= 1'b0;
    if (acc_valid && !rst) begin
      pend = notes.pop_front();
      check("trap_kill", {31'h0, trap_kill}, {31'h0, pend.kill});
      pend_v <= 1'b1;
    end
  end

  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    logic [31:0] v [8];
    logic [31:0] b;
    logic [6:0]  en;
    logic [2:0]  k;
    logic [1:0]  p;
    logic        h;
    void'($urandom(32'h8dd9));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      wr(2'h0, 32'(i));
      rd(2'h0, 32'(i));
      rd(2'h1, 32'h2080_0000);
      rd(2'h2, 32'h0000_0000);
    end
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      v[i] = $urandom;
      wr(2'h0, 32'(i));
      wr(2'h2, v[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(2'h0, 32'(i));
      rd(2'h2, v[i]);
    end
    $display("test address_rw done");
    wr(2'h0, 32'h0000_0001);
    wr(2'h1, 32'h0000_10DF);
    wr(2'h1, 32'hFFFF_FFFF);
    rd(2'h1, 32'h2080_18DF);
    wr(2'h1, 32'h0000_0000);
    $display("test legal_values done");
    b = $urandom;
    wr(2'h0, 32'h0000_0000);
    wr(2'h2, b);
    for (int i = 0; i < 24; i++) begin
      en = 7'($urandom) & 7'h5F;
      k = 3'b001 << ($urandom % 3);
      p = 2'($urandom % 3);
      if (p == 2'h2) p = 2'h3;
      h = |(k & en[2:0]) & (p == 2'h0 ? en[3] : p == 2'h1 ? en[4] : en[6]);
      wr(2'h1, {25'h0, en});
      acc(k, p, b, 3'h0, h, 1'b0);
      acc(k, p, b + 32'h1, 3'h0, 1'b0, 1'b0);
    end
    $display("test filters done");
    wr(2'h1, 32'h0000_105F);
    acc(3'b100, 2'h3, b, 3'h0, 1'b0, 1'b1);
    $display("test debug_action done");
    b = ($urandom & 32'h7FFF_FFE0) | 32'h0000_0100;
    wr(2'h2, b | 32'h0000_0003);
    wr(2'h1, 32'h0000_00DF);
    acc(3'b001, 2'h3, b + 32'h7, 3'h0, 1'b1, 1'b0);
    acc(3'b001, 2'h3, b + 32'h8, 3'h0, 1'b0, 1'b0);
    acc(3'b010, 2'h3, b - 32'h1, 3'h1, 1'b1, 1'b0);
    acc(3'b010, 2'h3, b - 32'h2, 3'h1, 1'b0, 1'b0);
    wr(2'h2, b | 32'h0000_0007);
    acc(3'b001, 2'h3, b + 32'hF, 3'h0, 1'b1, 1'b0);
    acc(3'b001, 2'h3, b + 32'h10, 3'h0, 1'b0, 1'b0);
    // A 32-byte pattern is past the largest range and must not widen the match
    wr(2'h2, b | 32'h0000_000F);
    acc(3'b001, 2'h3, b | 32'h0000_000F, 3'h0, 1'b1, 1'b0);
    acc(3'b001, 2'h3, b + 32'h10, 3'h0, 1'b0, 1'b0);
    $display("test power_of_two done");
    wr(2'h1, 32'h0000_0000);
    b = b + 32'h0000_1000;
    wr(2'h0, 32'h0000_0002);
    wr(2'h2, b);
    wr(2'h1, 32'h0000_095F);
    wr(2'h0, 32'h0000_0003);
    wr(2'h2, b + 32'h40);
    wr(2'h1, 32'h0000_01DF);
    acc(3'b100, 2'h0, b, 3'h0, 1'b1, 1'b0);
    acc(3'b100, 2'h1, b + 32'h3F, 3'h0, 1'b1, 1'b0);
    acc(3'b100, 2'h3, b + 32'h40, 3'h0, 1'b0, 1'b0);
    acc(3'b100, 2'h3, b - 32'h1, 3'h0, 1'b0, 1'b0);
    $display("test chained_range done");
    wr(2'h0, 32'h0000_0004);
    csr(1'b1, 2'h1, 32'h0800_005F, 1'b1, 32'h0000_0000, 1'b0);
    csr(1'b0, 2'h1, 32'h0000_0000, 1'b1, 32'h2880_005F, 1'b0);
    csr(1'b0, 2'h1, 32'h0000_0000, 1'b0, 32'h0000_0000, 1'b1);
    csr(1'b1, 2'h2, 32'h1234_5678, 1'b0, 32'h0000_0000, 1'b1);
    csr(1'b0, 2'h2, 32'h0000_0000, 1'b1, v[4], 1'b0);
    rd(2'h0, 32'h0000_0004);
    $display("test debug_only done");
    repeat (3) @(posedge sys_clk);
    summarize();
  end
endmodule : test_bpt_trigger_unit
